// [src/cbt_pkg.sv]
package cbt_pkg;
   // training enable, write set point and operating set point bits of the training control register
   localparam int TRAIN_EN_POS   = 0;
   localparam int WR_SP_SEL_POS  = 6;
   localparam int OP_SP_SEL_POS  = 7;
   // reference register field layout and command bit width
   localparam int REF_LEVEL_MSB  = 5;
   localparam int REF_RANGE_POS  = 6;
   localparam int REF_W          = 7;
   localparam int CA_W           = 6;
   // reset values
   localparam logic [6:0] REF_RESET     = 7'h4d;
   localparam logic       OP_SP_RESET   = 1'b0;
   // timing in ns, clock 25 ns
   localparam int CLK_PERIOD_NS        = 25;
   localparam int ENTRY_DELAY_NS       = 250;
   localparam int ENTRY_DELAY_CYC      =
      (ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MRW_DELAY_NS         = 250;
   localparam int MRW_DELAY_CYC        =
      (MRW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // mode register write from the host
   typedef struct packed {
      logic       valid;
      logic [5:0] addr;
      logic [7:0] data;
   } cbt_mrw_t;

   // training data pins seen from the die, 16 bits each
   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] oe;
   } cbt_dq_drv_t;

   typedef enum logic [3:0] {
      ST_NORMAL  = 4'b0001,
      ST_ARMED   = 4'b0010,
      ST_TRAIN   = 4'b0100,
      ST_EXITING = 4'b1000
   } cbt_state_t;

   localparam logic [5:0] MR_ADDR_CTRL = 6'h0d;
   localparam logic [5:0] MR_ADDR_REF  = 6'h0c;
endpackage

// [src/cbt_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of pin levels
module cbt_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_r;                 // first stage, read only by second

   // plain double flop; nothing but the second stage reads the first
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= pin_in;
         sync_out <= meta_r;
      end
   end
endmodule // cbt_sync

// [src/cbt_core.sv]
`timescale 1ns/1ps
module cbt_core #(
   parameter int ENTRY_CYC = cbt_pkg::ENTRY_DELAY_CYC,
   parameter int MRW_CYC   = cbt_pkg::MRW_DELAY_CYC
) (
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   input  wire cbt_pkg::cbt_mrw_t   mrw,
   input  wire logic                cke,
   input  wire logic                cs,
   input  wire logic [5:0]          ca,
   input  wire logic                strobe_lo,
   input  wire logic [15:0]         dq_in,
   output cbt_pkg::cbt_dq_drv_t     dq_drv,
   output logic                     operating_setpoint,
   output logic                     write_setpoint,
   output logic                     training_active,
   output logic [6:0]               command_reference_register
);
   // refuse delay counts that the 8-bit counter cannot hold
   if (ENTRY_CYC < 1 || ENTRY_CYC > 255 || MRW_CYC < 1 || MRW_CYC > 255) begin : g_bad_delay
      $error("cbt_core: delay counts out of range");
   end

   // synchronised pin levels; command bits too, host sets them ahead of select
   logic [15:0] pins_s;
   logic        cke_s;
   logic        cs_s;
   logic        strobe_s;
   logic [6:0]  dq_s;
   logic [5:0]  ca_s;
   cbt_sync #(.W(16)) u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin_in   ({cke, cs, strobe_lo, dq_in[6:0], ca}),
      .sync_out (pins_s)
   );
   assign {cke_s, cs_s, strobe_s, dq_s, ca_s} = pins_s;

   cbt_pkg::cbt_state_t state_r;        // training sequence state
   logic        train_en_r;             // training enable bit
   logic        saved_sp_r;             // set point active before entry
   logic        strobe_d_r;             // strobe edge history
   logic        cs_d_r;                 // select edge history
   logic [7:0]  cnt_r;                  // entry delay and exit settle counter
   logic [5:0]  ca_cap_r;               // command bits captured by select
   logic [6:0]  mr_ref_r;               // programmed reference value

   wire mrw_ctrl = mrw.valid && mrw.addr == cbt_pkg::MR_ADDR_CTRL;
   wire mrw_ref  = mrw.valid && mrw.addr == cbt_pkg::MR_ADDR_REF;
   wire strobe_edge = strobe_s ^ strobe_d_r;      // both edges capture
   wire cs_rise     = cs_s & ~cs_d_r;
   wire accept_ref  = (state_r == cbt_pkg::ST_TRAIN) && (cnt_r == 8'h00);

   // training enable and write set point written by mode register write
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         train_en_r     <= 1'b0;
         write_setpoint <= 1'b0;
      end else if (mrw_ctrl) begin
         train_en_r     <= mrw.data[cbt_pkg::TRAIN_EN_POS];
         write_setpoint <= mrw.data[cbt_pkg::WR_SP_SEL_POS];
      end
   end

   // sequence state; entry from idle or self refresh looks identical
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= cbt_pkg::ST_NORMAL;
         cnt_r   <= 8'h00;
      end else begin
         case (state_r)
            cbt_pkg::ST_NORMAL: begin
               // cke must already be high, so not in power down
               if (train_en_r && cke_s) begin
                  state_r <= cbt_pkg::ST_ARMED;
               end
            end
            cbt_pkg::ST_ARMED: begin
               if (!train_en_r) begin
                  state_r <= cbt_pkg::ST_NORMAL;
               end else if (!cke_s) begin
                  state_r <= cbt_pkg::ST_TRAIN;
                  cnt_r   <= 8'(ENTRY_CYC);
               end
            end
            cbt_pkg::ST_TRAIN: begin
               if (cnt_r != 8'h00) begin
                  cnt_r <= cnt_r - 8'h01;
               end
               if (cke_s) begin
                  state_r <= cbt_pkg::ST_EXITING;
               end
            end
            cbt_pkg::ST_EXITING: begin
               // wait for host to clear the enable bit, then settle
               if (!train_en_r && cnt_r == 8'h00) begin
                  state_r <= cbt_pkg::ST_NORMAL;
               end else if (!train_en_r) begin
                  cnt_r <= cnt_r - 8'h01;
               end else begin
                  cnt_r <= 8'(MRW_CYC);
               end
            end
            default: begin
               state_r <= cbt_pkg::ST_NORMAL;
            end
         endcase
      end
   end

   // set point swap on entry and restore on exit
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         operating_setpoint <= cbt_pkg::OP_SP_RESET;
         saved_sp_r         <= cbt_pkg::OP_SP_RESET;
      end else if (state_r == cbt_pkg::ST_ARMED && !cke_s && train_en_r) begin
         saved_sp_r         <= operating_setpoint;
         operating_setpoint <= ~operating_setpoint;
      end else if (state_r == cbt_pkg::ST_TRAIN && cke_s) begin
         operating_setpoint <= saved_sp_r;
      end else if (mrw_ctrl && state_r == cbt_pkg::ST_NORMAL) begin
         operating_setpoint <= mrw.data[cbt_pkg::OP_SP_SEL_POS];
      end
   end

   // programmed reference; only changes by mode write
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mr_ref_r <= cbt_pkg::REF_RESET;
      end else if (mrw_ref) begin
         mr_ref_r <= mrw.data[6:0];
      end
   end

   // live reference: strobed during training, programmed value otherwise
   // training values are dropped on exit rather than kept
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         command_reference_register <= cbt_pkg::REF_RESET;
         strobe_d_r                 <= 1'b0;
      end else begin
         strobe_d_r <= strobe_s;
         if (accept_ref && strobe_edge) begin
            // bit n from pin n; pin 7 and mask never looked at
            command_reference_register <= dq_s;
         end else if (state_r != cbt_pkg::ST_TRAIN) begin
            command_reference_register <= mr_ref_r;
         end
      end
   end

   // command bits captured on select rising edge
   // the core clock sees them late; real die returns them combinationally
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ca_cap_r <= '0;
         cs_d_r   <= 1'b0;
      end else begin
         cs_d_r <= cs_s;
         if (state_r == cbt_pkg::ST_TRAIN && cs_rise) begin
            ca_cap_r <= ca_s;
         end
      end
   end

   // pin drive: 13:8 outputs during training only, rest inputs or floating
   always_comb begin
      dq_drv.dout = 16'h0000;
      dq_drv.oe   = 16'h0000;
      if (state_r == cbt_pkg::ST_TRAIN) begin
         dq_drv.dout[13:8] = ca_cap_r;
         dq_drv.oe[13:8]   = 6'h3f;
      end
   end

   assign training_active = (state_r == cbt_pkg::ST_TRAIN);

   chk_swap_on_entry: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_r == cbt_pkg::ST_ARMED && !cke_s && train_en_r)
      |=> operating_setpoint != $past(operating_setpoint))
      else $error("set point did not swap on entry");
   chk_restore_exit: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_r == cbt_pkg::ST_TRAIN && cke_s) |=> operating_setpoint == saved_sp_r)
      else $error("set point not restored on exit");
   chk_reset_setpoint: assert property (@(posedge core_clk)
      !reset_n |-> operating_setpoint == 1'b0)
      else $error("set point not zero at reset");
   chk_ref_capture: assert property (@(posedge core_clk) disable iff (!reset_n)
      (accept_ref && strobe_edge) |=> command_reference_register == $past(dq_s))
      else $error("reference not captured from pins");
   chk_no_early_ref: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_r == cbt_pkg::ST_TRAIN && cnt_r != 8'h00 && $stable(state_r))
      |=> $stable(command_reference_register))
      else $error("reference changed before entry delay");
   chk_ca_return: assert property (@(posedge core_clk) disable iff (!reset_n)
      (training_active && cs_rise) ##1 training_active
      |-> dq_drv.dout[13:8] == $past(ca_s) && dq_drv.oe[13:8] == 6'h3f)
      else $error("captured command bits not on pins");
   chk_inputs_undriven: assert property (@(posedge core_clk) disable iff (!reset_n)
      dq_drv.oe[7:0] == 8'h00)
      else $error("input pins driven");
   chk_ref_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_r == cbt_pkg::ST_NORMAL && $past(state_r == cbt_pkg::ST_NORMAL))
      |-> command_reference_register == $past(mr_ref_r))
      else $error("trained reference kept outside training");
endmodule // cbt_core

// [tb/cbt_host_model.sv]
`timescale 1ns/1ps
// host controller side: mode writes, clock enable, select, strobed data
module cbt_host_model (
   input  wire logic         core_clk,
   output cbt_pkg::cbt_mrw_t mrw,
   output logic              cke,
   output logic              cs,
   output logic [5:0]        ca,
   output logic              strobe_lo,
   output logic [15:0]       dq_host
);
   // single rank: this die stands as the terminating one, trained first
   // idle: enable high so entry never starts from power down
   initial begin
      mrw       = '0;
      cke       = 1'b1;
      cs        = 1'b0;
      ca        = 6'h00;
      strobe_lo = 1'b0;
      dq_host   = 16'h2a00; // host level 2a on pins 13:8 wherever the die does not drive
   end
   // one write, taken at the next rising edge, then valid drops
   task automatic mr_wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge core_clk) mrw = {1'b1, a, d};
      @(negedge core_clk) mrw.valid = 1'b0;
   endtask
   // clock enable changes only at a falling edge
   task automatic set_cke(input logic v);
      @(negedge core_clk) cke = v;
   endtask
   // strobe toggles at 100 ns only during an update, stands still after
   task automatic vref(input logic [7:0] v, input int edges);
      @(negedge core_clk) dq_host[7:0] = v;
      dq_host[15:14] = ~dq_host[15:14]; // don't-care pins keep moving
      repeat (edges) begin
         @(negedge core_clk) strobe_lo = ~strobe_lo;
         repeat (3) @(negedge core_clk);
      end
   endtask
   // select pulse captures ca; select back low afterwards
   task automatic ca_cycle(input logic [5:0] v);
      @(negedge core_clk) ca = v;
      @(negedge core_clk) cs = 1'b1;
      repeat (2) @(negedge core_clk);
      cs = 1'b0;
   endtask
endmodule // cbt_host_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [5:0] ca;
      logic [5:0] dout;
   } cbt_row_t;                       // command bits beside expected echo
   logic                 core_clk = 1'b0;
   logic                 reset_n  = 1'b1;  // pulled low just after time zero
   cbt_pkg::cbt_mrw_t    mrw;
   logic                 cke;
   logic                 cs;
   logic                 strobe_lo;
   logic [5:0]           ca;
   logic [15:0]          dq_host;
   logic [15:0]          dq_in;      // resolved pin level
   cbt_pkg::cbt_dq_drv_t dq_drv;
   logic                 op_sp;
   logic                 wr_sp;
   logic                 trn;
   logic [6:0]           ref_lvl;
   int                   error_cnt = 0;
   int                   n_tests   = 0;
   cbt_row_t             rows [8] = '{'{6'h01, 6'h01}, '{6'h02, 6'h02}, '{6'h04, 6'h04},
      '{6'h08, 6'h08}, '{6'h10, 6'h10}, '{6'h20, 6'h20}, '{6'h3f, 6'h3f}, '{6'h15, 6'h15}};

   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;
   // die drives where enabled, host level elsewhere
   assign dq_in = (dq_drv.oe & dq_drv.dout) | (~dq_drv.oe & dq_host);

   // package default delays, ten cycles each
   cbt_core uut (
      .core_clk(core_clk), .reset_n(reset_n), .mrw(mrw), .cke(cke), .cs(cs),
      .ca(ca), .strobe_lo(strobe_lo), .dq_in(dq_in), .dq_drv(dq_drv),
      .operating_setpoint(op_sp), .write_setpoint(wr_sp),
      .training_active(trn), .command_reference_register(ref_lvl));

   cbt_host_model host (
      .core_clk(core_clk), .mrw(mrw), .cke(cke), .cs(cs), .ca(ca),
      .strobe_lo(strobe_lo), .dq_host(dq_host));

   // compare and count
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // single exit point of the run
   task automatic give_verdict();
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // watchdog: whole sequence is well under 2000 cycles
   initial begin
      #100us;
      error_cnt++;
      give_verdict();
   end

   initial begin
      #1 reset_n = 1'b0; // real falling edge, so the async reset fires
      cyc(20);
      reset_n = 1'b1;
      cyc(1);
      check("op_sp", 16'h0, op_sp);
      check("ref", 16'h004d, ref_lvl);
      check("oe", 16'h0, dq_drv.oe);
      host.mr_wr(cbt_pkg::MR_ADDR_CTRL, 8'h41);
      cyc(2);
      check("wr_sp", 16'h1, wr_sp);
      check("trn_armed", 16'h0, trn);
      host.set_cke(1'b0);
      cyc(7);
      check("trn", 16'h1, trn);
      check("op_sp", 16'h1, op_sp);
      check("oe", 16'h3f00, dq_drv.oe);
      host.vref(8'h15, 1);
      check("ref_early", 16'h004d, ref_lvl);
      cyc(12);
      host.vref(8'haa, 4);
      check("ref_a", 16'h002a, ref_lvl);
      host.vref(8'h55, 4);
      check("ref_b", 16'h0055, ref_lvl);
      cyc(10);
      // row loop: captured command bits echo on pins 13:8
      foreach (rows[i]) begin
         host.ca_cycle(rows[i].ca);
         cyc(4);
         check("echo", {10'h0, rows[i].dout}, {10'h0, dq_in[13:8]});
      end
      host.set_cke(1'b1);
      cyc(7);
      check("op_sp_exit", 16'h0, op_sp);
      check("ref_exit", 16'h004d, ref_lvl);
      cyc(10);
      host.mr_wr(cbt_pkg::MR_ADDR_CTRL, 8'h40);
      cyc(14);
      check("trn_off", 16'h0, trn);
      check("oe_off", 16'h0, dq_drv.oe);
      // programmed reference write outside training
      host.mr_wr(cbt_pkg::MR_ADDR_REF, 8'h33);
      cyc(2);
      check("ref_prog", 16'h0033, ref_lvl);
      // second pass starts from set point one
      host.mr_wr(cbt_pkg::MR_ADDR_CTRL, 8'hc1);
      cyc(2);
      check("op_sp_one", 16'h1, op_sp);
      host.set_cke(1'b0);
      cyc(7);
      check("op_sp_alt", 16'h0, op_sp);
      host.set_cke(1'b1);
      cyc(7);
      check("op_sp_back", 16'h1, op_sp);
      // reset in mid-run, before the enable bit is cleared
      reset_n = 1'b0;
      cyc(2);
      check("op_sp_rst", 16'h0, op_sp);
      check("trn_rst", 16'h0, trn);
      check("ref_rst", 16'h004d, ref_lvl);
      check("oe_rst", 16'h0, dq_drv.oe);
      check("wr_sp_rst", 16'h0, wr_sp);
      reset_n = 1'b1;
      cyc(4);
      check("op_sp_rel", 16'h0, op_sp);
      give_verdict();
   end
endmodule // testbench
